// ---- rtl/cstc_pkg.sv ----
package cstc_pkg;
   localparam logic [15:0] CSTC_CFG_OFFSET = 16'hffdf;
   // the printed offset is a word index: the byte address is four times it
   localparam logic [31:0] CSTC_CFG_ADDR = 32'h0003_ff7c;
   localparam logic [7:0] CSTC_CFG_RESET = 8'h00;
   localparam int CSTC_FSL_HI = 7;
   localparam int CSTC_FSL_LO = 6;
   localparam int CSTC_SDW_HI = 5;
   localparam int CSTC_SDW_LO = 3;
   localparam int CSTC_SL_HI = 2;
   localparam int CSTC_SL_LO = 0;
   localparam logic [1:0] CSTC_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] CSTC_HSIZE_WORD = 3'h2;
   localparam logic [5:0] CSTC_LEN_8 = 6'h08;
   localparam logic [5:0] CSTC_LEN_16 = 6'h10;
   localparam logic [5:0] CSTC_LEN_18 = 6'h12;
   localparam logic [5:0] CSTC_LEN_20 = 6'h14;
   localparam logic [5:0] CSTC_LEN_24 = 6'h18;
   localparam logic [5:0] CSTC_LEN_32 = 6'h20;
   localparam logic [5:0] CSTC_LEN_NONE = 6'h00;
   typedef enum logic [1:0] {
      CSTC_FSL_SAME = 2'b00,
      CSTC_FSL_8 = 2'b01,
      CSTC_FSL_16 = 2'b10,
      CSTC_FSL_32 = 2'b11
   } cstc_fsl_t;
endpackage : cstc_pkg

// ---- rtl/cstc_len_decode.sv ----
module cstc_len_decode
   import cstc_pkg::*;
(
   input wire logic [7:0] cfg,
   output logic [5:0] slot_len,
   output logic [5:0] first_len,
   output logic [5:0] data_width,
   output logic code_reserved,
   output logic width_over
);
   function automatic logic [5:0] len_code(input logic [2:0] code);
      case (code)
         3'h0: len_code = CSTC_LEN_8;
         3'h1: len_code = CSTC_LEN_16;
         3'h2: len_code = CSTC_LEN_18;
         3'h3: len_code = CSTC_LEN_20;
         3'h4: len_code = CSTC_LEN_24;
         3'h5: len_code = CSTC_LEN_32;
         default: len_code = CSTC_LEN_NONE;
      endcase
   endfunction : len_code

   always_comb begin
      slot_len = len_code(cfg[CSTC_SL_HI:CSTC_SL_LO]); // RL3 RL4
      data_width = len_code(cfg[CSTC_SDW_HI:CSTC_SDW_LO]); // RL6
      case (cstc_fsl_t'(cfg[CSTC_FSL_HI:CSTC_FSL_LO]))
         CSTC_FSL_8: first_len = CSTC_LEN_8; // RL1
         CSTC_FSL_16: first_len = CSTC_LEN_16; // RL1
         CSTC_FSL_32: first_len = CSTC_LEN_32; // RL1
         default: first_len = slot_len; // RL2
      endcase
      code_reserved = (slot_len == CSTC_LEN_NONE) || (data_width == CSTC_LEN_NONE); // RL5
      width_over = data_width > slot_len; // RL6
   end
endmodule : cstc_len_decode

// ---- rtl/cstc_slot_cfg.sv ----
// Operation
// [RL1] first slot codes 01,10,11 give 8,16,32
// [RL2] code 00: slot 0 like others
// [RL3] slot length codes give 8..32 cycles
// [RL4] slot length governs all slots but 0
// [RL5] software never writes reserved slot codes
// [RL6] data width code, not above slot length
//
// The implementer's own choice: register access over AHB-Lite.
module cstc_slot_cfg
   import cstc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [1:0] first_slot_length,
   output logic [2:0] slot_data_width,
   output logic [2:0] slot_length,
   output logic [5:0] first_slot_cycles,
   output logic [5:0] other_slot_cycles,
   output logic [5:0] data_bits,
   output logic cfg_reserved,
   output logic cfg_width_over
);
   typedef enum logic [1:0] {
      CSTC_PH_IDLE = 2'b00,
      CSTC_PH_WRITE = 2'b01,
      CSTC_PH_READ = 2'b10
   } cstc_phase_t;

   logic [7:0] cfg_r;
   cstc_phase_t phase_r;
   cstc_phase_t phase_nxt;
   logic rd_hit;
   logic wr_hit;
   logic [31:0] rd_word;
   logic [5:0] s_len;
   logic [5:0] f_len;
   logic [5:0] d_w;
   logic rsv;
   logic over;

   // the register answers only to its own word address
   function automatic logic cfg_selected(
      input logic sel,
      input logic rdy,
      input logic [1:0] trans,
      input logic [31:0] addr
   );
      cfg_selected = sel && rdy && (trans == CSTC_HTRANS_NONSEQ) && (addr == CSTC_CFG_ADDR);
   endfunction : cfg_selected

   always_comb begin
      rd_hit = 1'b0;
      wr_hit = 1'b0;
      if (cfg_selected(hsel, hready, htrans, haddr) && hwrite) begin
         wr_hit = 1'b1;
      end else if (cfg_selected(hsel, hready, htrans, haddr)) begin
         rd_hit = 1'b1;
      end
   end

   // data phase follows its address phase; the next address phase may overlap it
   always_comb begin
      if (wr_hit) begin
         phase_nxt = CSTC_PH_WRITE;
      end else if (rd_hit) begin
         phase_nxt = CSTC_PH_READ;
      end else begin
         phase_nxt = CSTC_PH_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_r <= CSTC_PH_IDLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // write data stands only in the data phase, so it is stored one edge late
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_r <= CSTC_CFG_RESET;
      end else begin
         case (phase_r)
            CSTC_PH_IDLE: cfg_r <= cfg_r;
            CSTC_PH_WRITE: cfg_r <= hwdata[7:0];
            CSTC_PH_READ: cfg_r <= cfg_r;
            default: cfg_r <= cfg_r;
         endcase
      end
   end

   // read word: register in the low byte, upper bits read as zero
   for (genvar b = 0; b < $bits(rd_word); b++) begin : g_rd_word
      if (b < $bits(cfg_r)) begin : g_cfg
         assign rd_word[b] = cfg_r[b];
      end else begin : g_zero
         assign rd_word[b] = 1'b0;
      end
   end

   // read data is driven for the data phase only and is zero otherwise
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_hit) begin
         hrdata <= rd_word;
      end else begin
         hrdata <= 32'h0000_0000;
      end
   end

   // zero wait states: every transfer completes in its first data-phase cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hreadyout <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   cstc_len_decode cstc_len_decode_inst (
      .cfg(cfg_r),
      .slot_len(s_len),
      .first_len(f_len),
      .data_width(d_w),
      .code_reserved(rsv),
      .width_over(over)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         first_slot_length <= CSTC_CFG_RESET[CSTC_FSL_HI:CSTC_FSL_LO];
      end else begin
         first_slot_length <= cfg_r[CSTC_FSL_HI:CSTC_FSL_LO];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slot_data_width <= CSTC_CFG_RESET[CSTC_SDW_HI:CSTC_SDW_LO];
      end else begin
         slot_data_width <= cfg_r[CSTC_SDW_HI:CSTC_SDW_LO];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slot_length <= CSTC_CFG_RESET[CSTC_SL_HI:CSTC_SL_LO];
      end else begin
         slot_length <= cfg_r[CSTC_SL_HI:CSTC_SL_LO];
      end
   end

   // cycle outputs reset to the lengths that the reset codes select
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         first_slot_cycles <= CSTC_LEN_8;
      end else begin
         first_slot_cycles <= f_len; // RL1 RL2
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         other_slot_cycles <= CSTC_LEN_8;
      end else begin
         other_slot_cycles <= s_len; // RL3 RL4
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_bits <= CSTC_LEN_8;
      end else begin
         data_bits <= d_w; // RL6
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_reserved <= 1'b0;
      end else begin
         cfg_reserved <= rsv; // RL5
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_width_over <= 1'b0;
      end else begin
         cfg_width_over <= over; // RL6
      end
   end
endmodule : cstc_slot_cfg

// ---- testbench/cstc_codec_model.sv ----
module cstc_codec_model (
   input wire logic [5:0] first_slot_cycles,
   input wire logic [5:0] other_slot_cycles,
   output logic [6:0] frame_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   // bit clocks the codec counts over slot 0 plus one later slot
   assign frame_bits = 7'(first_slot_cycles) + 7'(other_slot_cycles);
endmodule : cstc_codec_model

// ---- testbench/cstc_slot_checker.sv ----
module cstc_slot_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] first_slot_length,
   input wire logic [2:0] slot_data_width,
   input wire logic [2:0] slot_length,
   input wire logic [5:0] first_slot_cycles,
   input wire logic [5:0] other_slot_cycles,
   input wire logic [5:0] data_bits,
   input wire logic cfg_width_over
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] LT [8] = '{6'h08, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20, 6'h00, 6'h00};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_first_fixed: assert property (first_slot_length != 2'h0 |->
      first_slot_cycles == 6'h04 << first_slot_length) else $error("first slot");
   a_first_same: assert property (first_slot_length == 2'h0 |->
      first_slot_cycles == other_slot_cycles) else $error("slot 0 differs");
   a_other_len: assert property (other_slot_cycles == LT[slot_length])
      else $error("slot length");
   a_others_only: assert property ($changed(first_slot_length) && $stable(slot_length) |->
      $stable(other_slot_cycles)) else $error("slot 0 leaks");
   a_width_over: assert property (data_bits == LT[slot_data_width] &&
      cfg_width_over == (data_bits > other_slot_cycles)) else $error("data width");
   c_long_first: cover property (first_slot_length == 2'h3);
   c_long_slot: cover property (slot_length == 3'h5);
   c_over: cover property (cfg_width_over);
endmodule : cstc_slot_checker
bind cstc_slot_cfg cstc_slot_checker cstc_slot_checker_inst (.*);

// ---- testbench/cstc_slot_cfg_bench.sv ----
module cstc_slot_cfg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cstc_pkg::*;
   logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, cfg_reserved;
   logic cfg_width_over;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0, first_slot_length;
   logic [2:0] hsize = CSTC_HSIZE_WORD, slot_data_width, slot_length;
   logic [5:0] first_slot_cycles, other_slot_cycles, data_bits;
   logic [5:0] lt [8] = '{6'h08, 6'h10, 6'h12, 6'h14, 6'h18, 6'h20, 6'h00, 6'h00};
   logic [6:0] frame_bits;
   int err_total = 0, comparisons = 0;
   cstc_slot_cfg cstc_slot_cfg_inst (.*, .hready(hreadyout));
   cstc_codec_model cstc_codec_model_inst (.*);
   task automatic chk(input string n, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, d);
      {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, CSTC_HTRANS_NONSEQ};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic t_bus;
      bus(0, CSTC_CFG_ADDR, 0);
      chk("reset", 0, q);
      chk("ready", 1, hreadyout);
      chk("resp", 0, hresp);
      bus(1, CSTC_CFG_ADDR - 4, 32'h00ff);
      bus(0, CSTC_CFG_ADDR - 4, 0);
      chk("unmapped", 0, q);
      bus(0, CSTC_CFG_ADDR, 0);
      chk("kept", 0, q);
      chk("resp", 0, hresp);
   endtask : t_bus
   task automatic t_codes;
      logic [31:0] e;
      for (int s = 0; s < 6; s++) for (int f = 0; f < 4; f++) begin
         bus(1, CSTC_CFG_ADDR, {24'h0, f[1:0], 3'(7 - s), s[2:0]});
         bus(0, CSTC_CFG_ADDR, 0);
         chk("reg", {f[1:0], 3'(7 - s), s[2:0]}, q);
         chk("fields", {f[1:0], 3'(7 - s), s[2:0]}, {first_slot_length, slot_data_width, slot_length});
         e = f ? 32'h4 << f : lt[s];
         chk("first", e, first_slot_cycles);
         chk("other", lt[s], other_slot_cycles);
         chk("frame", e + lt[s], frame_bits);
         chk("data", lt[7 - s], data_bits);
         chk("over", lt[7 - s] > lt[s], cfg_width_over);
         chk("rsvd", s > 5 || s < 2, cfg_reserved);
      end
   endtask : t_codes
   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   initial forever #2 sys_clk = ~sys_clk;
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 0;
      t_bus();
      t_codes();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      stop_test();
   end
endmodule : cstc_slot_cfg_bench
